/* common/adc_cmp_regs.svh */
// Register offsets, field positions and timing counts of the compare/scan controller.
// Assumes AHB-Lite word access; byte addresses are offsets below.
`ifndef ADC_CMP_REGS_SVH
`define ADC_CMP_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_CHSEL 12'h004
`define OFS_WIN_A 12'h008
`define OFS_WIN_B 12'h00C
`define OFS_REF_A 12'h010
`define OFS_REF_B 12'h014
`define OFS_DISC 12'h018
`define OFS_STATUS 12'h01C
`define OFS_RESULT 12'h020
`define OFS_DIAG_RES 12'h024
`define OFS_DBL_RES 12'h028
`define OFS_SCAN_TIME 12'h02C
// Control register fields
`define CTRL_START 0
`define CTRL_CONT 1
`define CTRL_DBL 2
`define CTRL_DIAG 3
`define CTRL_CMP_EN 4
`define CTRL_EVT_EN 5
`define CTRL_BUF_EN 6
`define CTRL_CMP_B_EN 7
// Window select codes above the analog channels
`define SEL_TEMP 5'h10
`define SEL_VREF 5'h11
// Phase lengths in ns, rounded up to clock cycles at 100 MHz
`define START_DELAY_NS 50
`define END_DELAY_NS 30
`define CONV_NS 200
`define DIAG_NS 200
`define ASSIST_STATE_NS 10
`define CYC_NS 10
`define START_CYC ((`START_DELAY_NS + `CYC_NS - 1) / `CYC_NS)
`define END_CYC ((`END_DELAY_NS + `CYC_NS - 1) / `CYC_NS)
`define CONV_CYC ((`CONV_NS + `CYC_NS - 1) / `CYC_NS)
`define DIAG_CYC ((`DIAG_NS + `CYC_NS - 1) / `CYC_NS)
`define ASSIST_CYC ((`ASSIST_STATE_NS + `CYC_NS - 1) / `CYC_NS)
`endif

/* common/adc_cmp_pkg.sv */
// Types shared by the compare/scan controller.
// Assumes adc_cmp_regs.svh for numeric constants.
`default_nettype none
package adc_cmp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_ASSIST, ST_CONV, ST_DIAG, ST_END
    } scan_state_e;
    typedef struct packed {
        logic [4:0] sel;
        logic [11:0] low;
        logic [11:0] high;
        logic en;
    } window_s;
    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } sample_s;
endpackage
`default_nettype wire

/* verilog/window_cmp.sv */
// One compare window: in-range test of a sample against low/high references.
// Assumes sample and window from the same clock domain.
`default_nettype none
module window_cmp
    import adc_cmp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Compare request
    input wire window_s win,
    input wire logic [4:0] ch,
    input wire sample_s smp,
    // Result
    output logic hit_reg,
    output logic done_reg
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= smp.valid && win.en && (ch == win.sel);
            if (smp.valid && win.en && (ch == win.sel)) begin
                hit_reg <= (smp.data >= win.low) && (smp.data <= win.high);
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/adc_compare_window_scan.sv */
// Scan sequencer and window compare control of a 12-bit SAR converter.
// Assumes an AHB-Lite master, an analog core returning one sample per conversion slot.
`default_nettype none
`include "adc_cmp_regs.svh"
module adc_compare_window_scan
    import adc_cmp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Analog core
    input wire logic [11:0] conv_data,
    output logic [4:0] conv_ch_reg,
    output logic conv_go_reg,
    output logic assist_reg,
    // Compare events
    output logic match_evt_reg,
    output logic mismatch_evt_reg
);
    function automatic logic is_internal(input logic [4:0] s);
        is_internal = (s == `SEL_TEMP) || (s == `SEL_VREF);
    endfunction
    logic [7:0] ctrl_reg, phase_cnt_reg;
    logic [15:0] chsel_reg, scan_time_reg, scan_cnt_reg;
    logic [4:0] win_a_sel_reg, win_b_sel_reg;
    logic [23:0] ref_a_reg, ref_b_reg;
    logic [3:0] assist_state_count, ch_reg, next_ch;
    logic [11:0] result_reg, self_diag_result_reg, double_trigger_result_reg, addr_reg;
    logic busy_reg, a_hit_flag_reg, b_hit_flag_reg, wr_pend_reg, phase_done, have_next;
    scan_state_e state_reg;
    sample_s smp;
    window_s win_a, win_b;
    logic a_hit, a_done, b_hit, b_done, cmp_ok, start_req;
    // Bus: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 12'h000;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            addr_reg <= haddr;
        end
    end
    assign start_req = wr_pend_reg && addr_reg == `OFS_CTRL && hwdata[`CTRL_START];
    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= 8'h00;
            chsel_reg <= 16'h0000;
            win_a_sel_reg <= 5'h00;
            win_b_sel_reg <= 5'h00;
            ref_a_reg <= 24'h00_0000;
            ref_b_reg <= 24'h00_0000;
            assist_state_count <= 4'h0;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                `OFS_CTRL: ctrl_reg <= {hwdata[7:1], 1'b0};
                `OFS_CHSEL: chsel_reg <= hwdata[15:0];
                `OFS_WIN_A: win_a_sel_reg <= hwdata[4:0];
                `OFS_WIN_B: win_b_sel_reg <= hwdata[4:0];
                `OFS_REF_A: ref_a_reg <= hwdata[23:0];
                `OFS_REF_B: ref_b_reg <= hwdata[23:0];
                `OFS_DISC: assist_state_count <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // Compare is gated off in diagnosis and double-trigger modes
    assign cmp_ok = ctrl_reg[`CTRL_CMP_EN] && !ctrl_reg[`CTRL_DIAG]
        && !ctrl_reg[`CTRL_DBL];
    assign win_a.sel = win_a_sel_reg;
    assign win_a.low = ref_a_reg[11:0];
    assign win_a.high = ref_a_reg[23:12];
    assign win_a.en = cmp_ok && !is_internal(win_b_sel_reg);
    assign win_b.sel = win_b_sel_reg;
    assign win_b.low = ref_b_reg[11:0];
    assign win_b.high = ref_b_reg[23:12];
    assign win_b.en = cmp_ok && ctrl_reg[`CTRL_CMP_B_EN]
        && !is_internal(win_a_sel_reg)
        && (win_b_sel_reg != win_a_sel_reg);

    // Only ordinary channel conversions reach the windows
    assign smp.valid = (state_reg == ST_CONV) && phase_done;
    assign smp.data = conv_data;

    window_cmp u_win_a (
        .clk(clk),
        .rst_n(rst_n),
        .win(win_a),
        .ch({1'b0, ch_reg}),
        .smp(smp),
        .hit_reg(a_hit),
        .done_reg(a_done)
    );
    window_cmp u_win_b (
        .clk(clk),
        .rst_n(rst_n),
        .win(win_b),
        .ch({1'b0, ch_reg}),
        .smp(smp),
        .hit_reg(b_hit),
        .done_reg(b_done)
    );
    // Next selected channel above the current one
    always_comb begin
        next_ch = 4'h0;
        have_next = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            if (chsel_reg[i] && (i > int'(ch_reg))) begin
                next_ch = 4'(i);
                have_next = 1'b1;
            end
        end
    end

    function automatic logic [3:0] first_ch(input logic [15:0] m);
        first_ch = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (m[i]) begin
                first_ch = 4'(i);
            end
        end
    endfunction
    assign phase_done = (phase_cnt_reg == 8'h01);
    // Scan sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 8'h00;
            ch_reg <= 4'h0;
            busy_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: if (start_req && chsel_reg != 16'h0000) begin
                    state_reg <= ST_START;
                    phase_cnt_reg <= 8'(`START_CYC);
                    ch_reg <= first_ch(chsel_reg);
                    busy_reg <= 1'b1;
                end
                ST_START: if (phase_done) begin
                    if (assist_state_count == 4'h0) begin
                        state_reg <= ST_CONV;
                        phase_cnt_reg <= 8'(`CONV_CYC);
                    end else begin
                        state_reg <= ST_ASSIST;
                        phase_cnt_reg <= 8'(`ASSIST_CYC * assist_state_count);
                    end
                end else begin
                    phase_cnt_reg <= phase_cnt_reg - 8'h01;
                end
                ST_ASSIST: if (phase_done) begin
                    state_reg <= ST_CONV;
                    phase_cnt_reg <= 8'(`CONV_CYC);
                end else begin
                    phase_cnt_reg <= phase_cnt_reg - 8'h01;
                end
                ST_DIAG: if (phase_done) begin
                    state_reg <= ST_END;
                    phase_cnt_reg <= 8'(`END_CYC);
                end else begin
                    phase_cnt_reg <= phase_cnt_reg - 8'h01;
                end
                ST_CONV: if (phase_done) begin
                    if (have_next) begin
                        ch_reg <= next_ch;
                        state_reg <= (assist_state_count == 4'h0) ? ST_CONV : ST_ASSIST;
                        phase_cnt_reg <= (assist_state_count == 4'h0) ? 8'(`CONV_CYC)
                            : 8'(`ASSIST_CYC * assist_state_count);
                    end else begin
                        state_reg <= ctrl_reg[`CTRL_DIAG] ? ST_DIAG : ST_END;
                        phase_cnt_reg <= ctrl_reg[`CTRL_DIAG] ? 8'(`DIAG_CYC) : 8'(`END_CYC);
                    end
                end else begin
                    phase_cnt_reg <= phase_cnt_reg - 8'h01;
                end
                ST_END: if (phase_done) begin
                    if (ctrl_reg[`CTRL_CONT] && !ctrl_reg[`CTRL_EVT_EN]
                        && !ctrl_reg[`CTRL_BUF_EN]) begin
                        state_reg <= ST_START;
                        phase_cnt_reg <= 8'(`START_CYC);
                        ch_reg <= first_ch(chsel_reg);
                    end else begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'b0;
                    end
                end else begin
                    phase_cnt_reg <= phase_cnt_reg - 8'h01;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // Analog core drive and results
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conv_ch_reg <= 5'h00;
            conv_go_reg <= 1'b0;
            assist_reg <= 1'b0;
            result_reg <= 12'h000;
            self_diag_result_reg <= 12'h000;
            double_trigger_result_reg <= 12'h000;
            scan_cnt_reg <= 16'h0000;
            scan_time_reg <= 16'h0000;
        end else begin
            conv_ch_reg <= {1'b0, ch_reg};
            conv_go_reg <= (state_reg == ST_CONV);
            assist_reg <= (state_reg == ST_ASSIST);
            if (smp.valid) begin
                if (ctrl_reg[`CTRL_DBL]) begin
                    double_trigger_result_reg <= conv_data;
                end else begin
                    result_reg <= conv_data;
                end
            end
            if (state_reg == ST_DIAG && phase_done) begin
                self_diag_result_reg <= conv_data;
            end
            scan_cnt_reg <= (state_reg == ST_IDLE) ? 16'h0000 : scan_cnt_reg + 16'h0001;
            if (state_reg == ST_END && phase_done) begin
                scan_time_reg <= scan_cnt_reg + 16'h0001;
            end
        end
    end
    // Compare events and sticky hit flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_evt_reg <= 1'b0;
            mismatch_evt_reg <= 1'b0;
            a_hit_flag_reg <= 1'b0;
            b_hit_flag_reg <= 1'b0;
        end else begin
            match_evt_reg <= ctrl_reg[`CTRL_EVT_EN]
                && ((a_done && a_hit) || (b_done && b_hit));
            mismatch_evt_reg <= ctrl_reg[`CTRL_EVT_EN]
                && ((a_done && !a_hit) || (b_done && !b_hit));
            if (a_done && a_hit) begin
                a_hit_flag_reg <= 1'b1;
            end else if (wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[1]) begin
                a_hit_flag_reg <= 1'b0;
            end
            if (b_done && b_hit) begin
                b_hit_flag_reg <= 1'b1;
            end else if (wr_pend_reg && addr_reg == `OFS_STATUS && hwdata[2]) begin
                b_hit_flag_reg <= 1'b0;
            end
        end
    end
    // Read data, driven in the data phase
    always_comb begin
        case (addr_reg)
            `OFS_CTRL: hrdata = {24'h00_0000, ctrl_reg};
            `OFS_CHSEL: hrdata = {16'h0000, chsel_reg};
            `OFS_WIN_A: hrdata = {27'h000_0000, win_a_sel_reg};
            `OFS_WIN_B: hrdata = {27'h000_0000, win_b_sel_reg};
            `OFS_REF_A: hrdata = {8'h00, ref_a_reg};
            `OFS_REF_B: hrdata = {8'h00, ref_b_reg};
            `OFS_DISC: hrdata = {28'h000_0000, assist_state_count};
            `OFS_STATUS: hrdata = {26'h000_0000, win_b.en, win_a.en, state_reg == ST_IDLE,
                b_hit_flag_reg, a_hit_flag_reg, busy_reg};
            `OFS_RESULT: hrdata = {20'h0_0000, result_reg};
            `OFS_DIAG_RES: hrdata = {20'h0_0000, self_diag_result_reg};
            `OFS_DBL_RES: hrdata = {20'h0_0000, double_trigger_result_reg};
            `OFS_SCAN_TIME: hrdata = {16'h0000, scan_time_reg};
            default: hrdata = 32'h0000_0000;
        endcase
    end
endmodule
`default_nettype wire

/* sim/adc_scan_properties.sv */
// Port checker for the compare/scan controller.
// Assumes bind to adc_compare_window_scan; register writes are snooped on the bus.
`default_nettype none
`include "adc_cmp_regs.svh"
module adc_scan_checker
    import adc_cmp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    // Core and events
    input wire logic conv_go_reg,
    input wire logic assist_reg,
    input wire logic match_evt_reg,
    input wire logic mismatch_evt_reg
);
    logic [11:0] wa_reg;
    logic wv_reg;
    logic [3:0] cnt_reg;
    logic off_reg;
    logic [4:0] asn_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) begin
        wv_reg <= rst_n && hsel && htrans[1] && hready && hwrite;
        wa_reg <= haddr;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
            off_reg <= 1'b0;
        end else if (wv_reg && wa_reg == `OFS_DISC) begin
            cnt_reg <= hwdata[3:0];
        end else if (wv_reg && wa_reg == `OFS_CTRL) begin
            off_reg <= hwdata[3] | hwdata[2];
        end
    end
    // High cycles of the current assist run
    always_ff @(posedge clk) begin
        if (!rst_n || !assist_reg) begin
            asn_reg <= 5'h00;
        end else begin
            asn_reg <= asn_reg + 5'h01;
        end
    end
    diag_no_event_a: assert property (off_reg |-> !match_evt_reg && !mismatch_evt_reg)
        else $error("compare event while diagnosis or double trigger set");
    assist_skip_a: assert property (cnt_reg == 4'h0 |-> !assist_reg)
        else $error("assist active with zero state count");
    assist_len_a: assert property ($fell(assist_reg) |-> asn_reg == cnt_reg * `ASSIST_CYC)
        else $error("assist run length wrong");
    conv_len_a: assert property ($rose(conv_go_reg) |-> conv_go_reg[*8] ##12 conv_go_reg)
        else $error("conversion slot too short");
    phase_excl_a: assert property (!(assist_reg && conv_go_reg))
        else $error("assist overlaps conversion");
    cover property ($fell(assist_reg));
    cover property ($rose(conv_go_reg) && off_reg);
    cover property (match_evt_reg || mismatch_evt_reg);
endmodule
bind adc_compare_window_scan adc_scan_checker chk (.clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .conv_go_reg, .assist_reg, .match_evt_reg, .mismatch_evt_reg);
`default_nettype wire

/* sim/adc_compare_window_scan_tb.sv */
// Self-checking bench for the compare/scan controller.
// Assumes a zero-wait AHB-Lite slave and a 100 MHz clock.
`default_nettype none
`include "adc_cmp_regs.svh"
module adc_compare_window_scan_tb
    import adc_cmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready;
    logic [11:0] haddr = 12'h000, conv_data = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic hreadyout, hresp, conv_go_reg, assist_reg, match_evt_reg, mismatch_evt_reg;
    logic [4:0] conv_ch_reg;
    int n_mismatch = 0, cmp_count = 0, seed = 54002, lo, hi, d, n, ex;
    int n_mat = 0, n_mis = 0, n_go = 0, last_ch = 0, m0, u0, g0;
    adc_compare_window_scan dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .conv_data, .conv_ch_reg,
        .conv_go_reg, .assist_reg, .match_evt_reg, .mismatch_evt_reg);
    initial begin
        forever #5 clk = ~clk;
    end
    // The one slave's ready is the bus ready
    assign hready = hreadyout;
    // Event pulses, conversion cycles and last converted channel
    always @(posedge clk) begin
        if (rst_n) begin
            n_mat += match_evt_reg;
            n_mis += mismatch_evt_reg;
            n_go += conv_go_reg;
            if (conv_go_reg) last_ch = conv_ch_reg;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("Error at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dat);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    // Start a single scan and poll busy until it drops
    task automatic scan(input logic [31:0] ctl);
        m0 = n_mat;
        u0 = n_mis;
        g0 = n_go;
        bus(1'b1, `OFS_CTRL, ctl | 32'h0000_0001);
        wait_idle();
    endtask
    task automatic wait_idle;
        rd = 32'h0000_0001;
        for (int i = 0; i < 400 && rd[0]; i++) bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk(rd[0], 1'b0);
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        $display("Error at %0t: run timed out", $time);
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, `OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b1, 12'h040, 32'hFFFF_FFFF);
        bus(1'b0, 12'h040, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("Test reset and unmapped done");
        // Assist counts 0, 2, 3 over 1 to 3 channels, diagnosis on the last
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 0 : k + 1;
            n = k + 1;
            bus(1'b1, `OFS_DISC, d);
            bus(1'b1, `OFS_CHSEL, (1 << n) - 1);
            scan((k == 2) ? 32'h0000_0008 : 32'h0000_0000);
            bus(1'b0, `OFS_SCAN_TIME, 32'h0000_0000);
            ex = `START_CYC + n * (d * `ASSIST_CYC + `CONV_CYC) + `END_CYC;
            chk(rd, ex + ((k == 2) ? `DIAG_CYC : 0));
            chk(n_go - g0, n * `CONV_CYC);
            chk(last_ch, n - 1);
        end
        $display("Test scan timing done");
        bus(1'b1, `OFS_DISC, 32'h0000_0000);
        bus(1'b1, `OFS_CHSEL, 32'h0000_0002);
        bus(1'b1, `OFS_WIN_A, 32'h0000_0001);
        bus(1'b1, `OFS_WIN_B, 32'h0000_0005);
        // Last two scans add diagnosis or double trigger: compare must stay off
        for (int k = 0; k < 6; k++) begin
            lo = $random(seed) & 32'h0000_0FFF;
            hi = $random(seed) & 32'h0000_0FFF;
            if (lo > hi) begin
                d = lo;
                lo = hi;
                hi = d;
            end
            conv_data <= 12'($random(seed));
            bus(1'b1, `OFS_STATUS, 32'h0000_0006);
            bus(1'b1, `OFS_REF_A, (hi << 12) | lo);
            scan(k < 4 ? 32'h0000_0030 : (k == 4 ? 32'h0000_0038 : 32'h0000_0034));
            ex = conv_data >= lo && conv_data <= hi;
            bus(1'b0, `OFS_STATUS, 32'h0000_0000);
            chk(rd[1], k < 4 && ex);
            chk(n_mat - m0, k < 4 && ex);
            chk(n_mis - u0, k < 4 && !ex);
            chk(last_ch, 1);
            bus(1'b0, k == 5 ? `OFS_DBL_RES : `OFS_RESULT, 32'h0000_0000);
            chk(rd, conv_data);
        end
        $display("Test window compare done");
        // Continuous scan repeats only without event or buffer output
        for (int k = 0; k < 3; k++) begin
            ex = (k == 0) ? 32'h0000_0003 : ((k == 1) ? 32'h0000_0023 : 32'h0000_0043);
            bus(1'b1, `OFS_CTRL, ex);
            repeat (100) @(posedge clk);
            bus(1'b0, `OFS_STATUS, 32'h0000_0000);
            chk(rd[0], k == 0);
            bus(1'b1, `OFS_CTRL, 32'h0000_0000);
            wait_idle();
        end
        $display("Test scan mode fallback done");
        bus(1'b1, `OFS_CTRL, 32'h0000_0090);
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, `OFS_WIN_A, k == 0 ? `SEL_TEMP : (k == 1 ? `SEL_VREF : 2));
            bus(1'b1, `OFS_WIN_B, k == 2 ? `SEL_TEMP : (k == 3 ? `SEL_VREF : 3));
            bus(1'b0, `OFS_STATUS, 32'h0000_0000);
            chk(rd[5:4], {k > 1, k < 2 || k == 4});
        end
        $display("Test window enables done");
        end_sim();
    end
endmodule
`default_nettype wire
